// ===== inc/chgi_defines.svh
// constants of the charger two-wire slave: addresses, fields, reset values, timing
`ifndef CHGI_DEFINES_SVH
`define CHGI_DEFINES_SVH
`define CHGI_SLAVE_ADDR 7'h6B
`define CHGI_HS_CODE 5'h01
`define CHGI_DIR_WRITE 1'b1
`define CHGI_REG_STATUS 8'h00
`define CHGI_REG_CTRL 8'h01
`define CHGI_UNMAPPED 8'hFF
`define CHGI_EN_STAT_RST 1'b1
`define CHGI_CTRL_RST 8'h30
`define CHGI_B_KICK 7
`define CHGI_B_EN_STAT 6
`define CHGI_F_STATE 5:4
`define CHGI_B_SPARE 3
`define CHGI_F_FAULT 2:0
`define CHGI_F_ILIM 7:6
`define CHGI_F_ACC_LIM 5:4
`define CHGI_B_TERM 3
`define CHGI_B_CHG_DIS 2
`define CHGI_B_HIZ 1
`define CHGI_B_ACC_EN 0
`define CHGI_CHG_CHARGING 2'h1
`define CHGI_CHG_FAULT 2'h3
`define CHGI_ILIM_PSEL_LO 2'h0
`define CHGI_ILIM_PSEL_HI 2'h1
`define CHGI_BIT_LAST 4'h8
`define CHGI_CLK_MHZ 10
`define CHGI_FAULT_PULSE_US 128
`define CHGI_FAULT_PULSE_CYC (`CHGI_FAULT_PULSE_US * `CHGI_CLK_MHZ)
`define CHGI_PULSE_W 11
`define CHGI_FIFO_DEPTH 8
`define CHGI_FIFO_W 16
`endif

// ===== inc/chgi_pkg.sv
// types shared by the charger two-wire slave
package chgi_pkg;
	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_ADDR = 7'h02,
		S_ADDR_ACK = 7'h04,
		S_RX = 7'h08,
		S_RX_ACK = 7'h10,
		S_TX = 7'h20,
		S_TX_ACK = 7'h40
	} chgi_state_t;
	// one register write travelling through the buffer
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} chgi_wrec_t;
	// status reported by the charging core
	typedef struct packed {
		logic [1:0] state;
		logic [2:0] fault;
	} chgi_status_t;
endpackage

// ===== rtl/chgi_top.sv
// charger two-wire slave with status and control registers, plus its write buffer
`timescale 1ns/10ps
`include "chgi_defines.svh"

module chgi_fifo #(
	parameter int W = 16,
	parameter int D = 8
) (
	input wire logic clk_sys, // system clock
	input wire logic rst_n, // synchronised reset, active low
	input wire logic [W-1:0] in_data, // word to store
	input wire logic in_valid, // store request
	output logic in_ready, // room for a word
	output logic [W-1:0] out_data, // oldest word
	output logic out_valid, // a word is waiting
	input wire logic out_ready // consumer takes the word
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_q [D];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic full;
	logic empty;

	// pointers carry one extra bit so full and empty differ
	assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign empty = (wr_q == rd_q);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem_q[rd_q[AW-1:0]];

	// storage
	always_ff @(posedge clk_sys) begin
		if (in_valid && !full) begin
			mem_q[wr_q[AW-1:0]] <= in_data;
		end
	end

	// pointers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (in_valid && !full) begin
				wr_q <= wr_q + 1'b1;
			end
			if (out_ready && !empty) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule

module chgi_top (
	input wire logic clk_sys, // 10 MHz system clock
	input wire logic nrst, // asynchronous reset, active low
	input wire logic scl_in, // serial clock pin level
	input wire logic sda_in, // serial data pin level
	output logic sda_out, // serial data drive value, always low
	output logic sda_oe_n, // low while pulling serial data low
	input wire logic psel_in, // power source select pin
	input wire logic default_mode, // charger runs in default mode
	input chgi_pkg::chgi_status_t charger_status, // charge state and fault code
	input wire logic reg_hold, // charging core stalls register updates
	output logic stat_oe_n, // status pin, low while pulled low
	output logic int_oe_n, // interrupt pin, low while pulled low
	output logic watchdog_kick, // one-cycle watchdog restart
	output logic [1:0] input_limit, // effective input current limit code
	output logic [1:0] accessory_limit, // accessory output limit code
	output logic termination_enable, // charge termination enabled
	output logic charge_disable, // charging disabled
	output logic high_impedance_select, // high impedance mode
	output logic accessory_output_enable, // accessory output enabled
	output logic hs_mode // high-speed settings active
);
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic [2:0] scl_sync_q;
	logic [2:0] sda_sync_q;
	logic [2:0] psel_sync_q;
	logic scl_f_q;
	logic sda_f_q;
	logic scl_p_q;
	logic sda_p_q;
	logic psel_q;
	logic start_c;
	logic stop_c;
	logic scl_rise;
	logic scl_fall;
	chgi_pkg::chgi_state_t state_q;
	logic [3:0] bitcnt_q;
	logic [7:0] sreg_q;
	logic [7:0] tx_q;
	logic [7:0] ptr_q;
	logic ptr_seen_q;
	logic dir_wr_q;
	logic ack_q;
	logic sda_low_q;
	logic push_c;
	logic fifo_in_ready;
	chgi_pkg::chgi_wrec_t wrec_in;
	chgi_pkg::chgi_wrec_t wrec_out;
	logic fifo_out_valid;
	logic pop_c;
	logic en_stat_q;
	logic [7:0] ctrl_q;
	logic [1:0] ilim_q;
	logic kick_q;
	logic [1:0] chg_prev_q;
	logic [`CHGI_PULSE_W-1:0] pulse_q;
	logic pin_low_q;
	logic [7:0] rd_c;

	// register readback; unknown addresses read as all ones
	function automatic logic [7:0] rd_byte(input logic [7:0] a);
		logic [7:0] r;
		r = `CHGI_UNMAPPED;
		if (a == `CHGI_REG_STATUS) begin
			r = '0;
			r[`CHGI_B_KICK] = psel_q;
			r[`CHGI_B_EN_STAT] = en_stat_q;
			r[`CHGI_F_STATE] = charger_status.state;
			r[`CHGI_B_SPARE] = 1'b0;
			r[`CHGI_F_FAULT] = charger_status.fault;
		end else if (a == `CHGI_REG_CTRL) begin
			r = ctrl_q;
		end
		return r;
	endfunction

	// byte at the pointer, ready before the falling clock that starts its first bit
	always_comb begin
		rd_c = rd_byte(ptr_q);
	end

	// reset release through two flops
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// three-flop sampling; a level counts only once stages two and three agree
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			scl_sync_q <= 3'h7;
			sda_sync_q <= 3'h7;
			psel_sync_q <= 3'h0;
			scl_f_q <= 1'b1;
			sda_f_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			psel_q <= 1'b0;
		end else begin
			scl_sync_q <= {scl_sync_q[1:0], scl_in};
			sda_sync_q <= {sda_sync_q[1:0], sda_in};
			psel_sync_q <= {psel_sync_q[1:0], psel_in};
			if (scl_sync_q[1] == scl_sync_q[2]) begin
				scl_f_q <= scl_sync_q[2];
			end
			if (sda_sync_q[1] == sda_sync_q[2]) begin
				sda_f_q <= sda_sync_q[2];
			end
			if (psel_sync_q[1] == psel_sync_q[2]) begin
				psel_q <= psel_sync_q[2];
			end
			scl_p_q <= scl_f_q;
			sda_p_q <= sda_f_q;
		end
	end

	// bus conditions from the filtered levels
	assign start_c = scl_f_q && scl_p_q && sda_p_q && !sda_f_q;
	assign stop_c = scl_f_q && scl_p_q && !sda_p_q && sda_f_q;
	assign scl_rise = scl_f_q && !scl_p_q;
	assign scl_fall = !scl_f_q && scl_p_q;

	// byte engine; the slave never drives the clock, so no stretching is possible
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= chgi_pkg::S_IDLE;
			bitcnt_q <= 4'h0;
			sreg_q <= 8'h00;
			tx_q <= 8'hFF;
			ptr_q <= 8'h00;
			ptr_seen_q <= 1'b0;
			dir_wr_q <= 1'b1;
			ack_q <= 1'b0;
			sda_low_q <= 1'b0;
			hs_mode <= 1'b0;
		end else if (start_c) begin
			// repeated START keeps high-speed settings
			state_q <= chgi_pkg::S_ADDR;
			bitcnt_q <= 4'h0;
			sda_low_q <= 1'b0;
		end else if (stop_c) begin
			// a STOP also recovers from any half-finished transfer
			state_q <= chgi_pkg::S_IDLE;
			sda_low_q <= 1'b0;
			hs_mode <= 1'b0;
		end else begin
			unique case (state_q)
				chgi_pkg::S_IDLE: begin
					sda_low_q <= 1'b0;
				end
				chgi_pkg::S_ADDR: begin
					if (scl_rise) begin
						sreg_q <= {sreg_q[6:0], sda_f_q};
						bitcnt_q <= bitcnt_q + 4'h1;
					end else if (scl_fall && bitcnt_q == `CHGI_BIT_LAST) begin
						if (sreg_q[7:1] == `CHGI_SLAVE_ADDR) begin
							state_q <= chgi_pkg::S_ADDR_ACK;
							sda_low_q <= 1'b1;
							dir_wr_q <= (sreg_q[0] == `CHGI_DIR_WRITE);
						end else begin
							// foreign address or master code: no acknowledge; only the master code switches speed settings
							if (sreg_q[7:3] == `CHGI_HS_CODE) begin
								hs_mode <= 1'b1;
							end
							state_q <= chgi_pkg::S_IDLE;
						end
					end
				end
				chgi_pkg::S_ADDR_ACK: begin
					if (scl_fall) begin
						bitcnt_q <= 4'h0;
						if (dir_wr_q) begin
							state_q <= chgi_pkg::S_RX;
							sda_low_q <= 1'b0;
							ptr_seen_q <= 1'b0;
						end else begin
							state_q <= chgi_pkg::S_TX;
							tx_q <= rd_c;
							sda_low_q <= !rd_c[7];
							ptr_q <= ptr_q + 8'h01;
						end
					end
				end
				chgi_pkg::S_RX: begin
					if (scl_rise) begin
						sreg_q <= {sreg_q[6:0], sda_f_q};
						bitcnt_q <= bitcnt_q + 4'h1;
					end else if (scl_fall && bitcnt_q == `CHGI_BIT_LAST) begin
						if (!ptr_seen_q) begin
							ptr_q <= sreg_q;
							ptr_seen_q <= 1'b1;
							state_q <= chgi_pkg::S_RX_ACK;
							sda_low_q <= 1'b1;
						end else if (fifo_in_ready) begin
							ptr_q <= ptr_q + 8'h01;
							state_q <= chgi_pkg::S_RX_ACK;
							sda_low_q <= 1'b1;
						end else begin
							// buffer full: the byte is refused with a NACK
							state_q <= chgi_pkg::S_IDLE;
						end
					end
				end
				chgi_pkg::S_RX_ACK: begin
					if (scl_fall) begin
						state_q <= chgi_pkg::S_RX;
						sda_low_q <= 1'b0;
						bitcnt_q <= 4'h0;
					end
				end
				chgi_pkg::S_TX: begin
					if (scl_rise) begin
						bitcnt_q <= bitcnt_q + 4'h1;
					end else if (scl_fall) begin
						if (bitcnt_q == `CHGI_BIT_LAST) begin
							state_q <= chgi_pkg::S_TX_ACK;
							sda_low_q <= 1'b0;
						end else begin
							tx_q <= {tx_q[6:0], 1'b1};
							sda_low_q <= !tx_q[6];
						end
					end
				end
				chgi_pkg::S_TX_ACK: begin
					if (scl_rise) begin
						ack_q <= !sda_f_q;
					end else if (scl_fall) begin
						bitcnt_q <= 4'h0;
						if (ack_q) begin
							state_q <= chgi_pkg::S_TX;
							tx_q <= rd_c;
							sda_low_q <= !rd_c[7];
							ptr_q <= ptr_q + 8'h01;
						end else begin
							state_q <= chgi_pkg::S_IDLE;
						end
					end
				end
			endcase
		end
	end
	assign sda_out = 1'b0;
	assign sda_oe_n = !sda_low_q;

	// received data bytes enter the buffer on their acknowledge
	assign push_c = (state_q == chgi_pkg::S_RX) && !start_c && !stop_c && scl_fall
		&& (bitcnt_q == `CHGI_BIT_LAST) && ptr_seen_q;
	assign wrec_in.addr = ptr_q;
	assign wrec_in.data = sreg_q;

	chgi_fifo #(
		.W(`CHGI_FIFO_W),
		.D(`CHGI_FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.in_data(wrec_in),
		.in_valid(push_c),
		.in_ready(fifo_in_ready),
		.out_data(wrec_out),
		.out_valid(fifo_out_valid),
		.out_ready(!reg_hold)
	);
	assign pop_c = fifo_out_valid && !reg_hold;

	// register file; writes to unknown addresses are dropped
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			en_stat_q <= `CHGI_EN_STAT_RST;
			ctrl_q <= `CHGI_CTRL_RST;
			kick_q <= 1'b0;
		end else begin
			kick_q <= 1'b0;
			if (pop_c && wrec_out.addr == `CHGI_REG_STATUS) begin
				kick_q <= wrec_out.data[`CHGI_B_KICK];
				en_stat_q <= wrec_out.data[`CHGI_B_EN_STAT];
			end
			if (pop_c && wrec_out.addr == `CHGI_REG_CTRL) begin
				ctrl_q <= wrec_out.data;
			end
		end
	end
	assign watchdog_kick = kick_q;
	assign accessory_limit = ctrl_q[`CHGI_F_ACC_LIM];
	assign termination_enable = ctrl_q[`CHGI_B_TERM];
	assign charge_disable = ctrl_q[`CHGI_B_CHG_DIS];
	assign high_impedance_select = ctrl_q[`CHGI_B_HIZ];
	assign accessory_output_enable = ctrl_q[`CHGI_B_ACC_EN];

	// effective input limit; default mode ignores the programmed field
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ilim_q <= 2'h0;
		end else if (default_mode) begin
			ilim_q <= psel_q ? `CHGI_ILIM_PSEL_HI : `CHGI_ILIM_PSEL_LO;
		end else begin
			ilim_q <= ctrl_q[`CHGI_F_ILIM];
		end
	end
	assign input_limit = ilim_q;

	// status pins: held low while charging, one timed pulse on entering fault
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			chg_prev_q <= 2'h0;
			pulse_q <= '0;
			pin_low_q <= 1'b0;
		end else begin
			chg_prev_q <= charger_status.state;
			if (charger_status.state == `CHGI_CHG_FAULT && chg_prev_q != `CHGI_CHG_FAULT) begin
				pulse_q <= `CHGI_PULSE_W'(`CHGI_FAULT_PULSE_CYC);
			end else if (pulse_q != '0) begin
				pulse_q <= pulse_q - 1'b1;
			end
			pin_low_q <= en_stat_q && ((charger_status.state == `CHGI_CHG_CHARGING)
				|| (pulse_q != '0));
		end
	end
	assign stat_oe_n = !pin_low_q;
	assign int_oe_n = !pin_low_q;

	// checks
	sequence addr_done;
		state_q == chgi_pkg::S_ADDR && scl_fall && !start_c && !stop_c
			&& bitcnt_q == `CHGI_BIT_LAST;
	endsequence
	sequence fault_entry;
		charger_status.state == `CHGI_CHG_FAULT && chg_prev_q != `CHGI_CHG_FAULT && en_stat_q;
	endsequence

	a_addr_match_ack: assert property (@(posedge clk_sys) disable iff (!rst_n)
		addr_done and (sreg_q[7:1] == `CHGI_SLAVE_ADDR) |=> sda_low_q && !sda_oe_n)
		else $error("matching address not acknowledged");
	a_addr_other_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
		addr_done and (sreg_q[7:1] != `CHGI_SLAVE_ADDR) |=> !sda_low_q)
		else $error("foreign address acknowledged");
	a_hs_code_enter: assert property (@(posedge clk_sys) disable iff (!rst_n)
		addr_done and (sreg_q[7:3] == `CHGI_HS_CODE) |=> hs_mode && sda_oe_n)
		else $error("master code mishandled");
	a_stop_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
		stop_c |=> !hs_mode && sda_oe_n && state_q == chgi_pkg::S_IDLE)
		else $error("stop did not release the bus");
	a_start_any: assert property (@(posedge clk_sys) disable iff (!rst_n)
		start_c |=> state_q == chgi_pkg::S_ADDR && bitcnt_q == 4'h0)
		else $error("start not detected");
	a_unmapped_ones: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_q == chgi_pkg::S_ADDR_ACK && scl_fall && !start_c && !stop_c && !dir_wr_q
			&& ptr_q > `CHGI_REG_CTRL |=> tx_q == `CHGI_UNMAPPED)
		else $error("undefined address did not read FF");
	a_kick_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pop_c && wrec_out.addr == `CHGI_REG_STATUS && wrec_out.data[`CHGI_B_KICK]
			|=> watchdog_kick ##1 !watchdog_kick)
		else $error("watchdog kick not a single pulse");
	a_ctrl_reset_val: assert property (@(posedge clk_sys)
		$rose(rst_n) |-> ctrl_q == `CHGI_CTRL_RST && en_stat_q)
		else $error("control registers left reset with wrong value");
	a_ilim_psel: assert property (@(posedge clk_sys) disable iff (!rst_n)
		default_mode && $stable(psel_q) |=> input_limit ==
			($past(psel_q) ? `CHGI_ILIM_PSEL_HI : `CHGI_ILIM_PSEL_LO))
		else $error("input limit ignores power select in default mode");
	a_fault_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
		fault_entry ##1 en_stat_q |=> !stat_oe_n && !int_oe_n)
		else $error("fault pulse missing on status pins");
endmodule

// ===== dv/chgi_master.sv
// bus master model that clocks the charger slave and moves bytes over the data line
`timescale 1ns/10ps
module chgi_master (
	input wire logic clk_sys, // bench clock, paces every bus phase
	input wire logic sda, // resolved data line level
	output logic scl, // serial clock, stands high between frames
	output logic sda_low // high while the master pulls data low
);
	// link clock of 8 system clocks (800 ns): low for 6, high for 2; the long low phase
	// is needed because the slave answers 5 clocks after the falling pin clock
	localparam int T_HOLD = 1;
	localparam int T_SETUP = 5;
	localparam int T_HIGH = 1;
	localparam int T_COND = 3;
	localparam int T_GAP = 8;
	// idle bus: both lines released to the pull-ups
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic wc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// start or repeated start: data falls while the clock is high, ends on a clock fall
	task automatic start();
		wc(T_HOLD);
		sda_low <= 1'b0;
		wc(T_SETUP);
		scl <= 1'b1;
		wc(T_COND);
		sda_low <= 1'b1;
		wc(T_COND);
		scl <= 1'b0;
	endtask
	// stop: data rises while the clock is high, also ends any cut-short transfer
	task automatic stop();
		wc(T_HOLD);
		sda_low <= 1'b1;
		wc(T_SETUP);
		scl <= 1'b1;
		wc(T_COND);
		sda_low <= 1'b0;
		wc(T_GAP);
	endtask
	// one bit: data set one clock after the fall, sampled in the high phase
	task automatic bit_io(input logic b, output logic r);
		wc(T_HOLD);
		sda_low <= ~b;
		wc(T_SETUP);
		scl <= 1'b1;
		wc(T_HIGH);
		r = sda;
		wc(T_HIGH);
		scl <= 1'b0;
	endtask
	// a byte msb first, then the acknowledge bit from the receiving side
	task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
		output logic ack);
		for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
		bit_io(ack_in, ack);
	endtask
endmodule

// ===== dv/chgi_top_tb.sv
// self-checking bench for the charger two-wire slave and its two registers
`timescale 1ns/10ps
`include "chgi_defines.svh"
module chgi_top_tb;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic psel_in = 1'b0;
	logic default_mode = 1'b0;
	logic reg_hold = 1'b0;
	chgi_pkg::chgi_status_t charger_status = 5'h00;
	logic scl, m_low, sda_line, sda_out, sda_oe_n, stat_oe_n, int_oe_n, kick, hs_mode;
	logic [1:0] input_limit, acc_lim;
	logic term_en, chg_dis, hiz, acc_en, a, ack;
	logic [7:0] x, rd;
	int n_mismatch = 0;
	int check_count = 0;
	int kicks = 0;
	int cyc = 0;
	int ctrl_m = 32'h30; // model of the control register
	int en_m = 1; // model of the status pin enable
	int k0, n;

	always #50 clk_sys = ~clk_sys;
	// open-drain data line with pull-up, resolved from both drivers
	assign sda_line = ~m_low & (sda_oe_n | sda_out);

	chgi_master i_master (.clk_sys(clk_sys), .sda(sda_line), .scl(scl), .sda_low(m_low));
	chgi_top i_dut (.clk_sys(clk_sys), .nrst(nrst), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .psel_in(psel_in), .default_mode(default_mode),
		.charger_status(charger_status), .reg_hold(reg_hold), .stat_oe_n(stat_oe_n),
		.int_oe_n(int_oe_n), .watchdog_kick(kick), .input_limit(input_limit),
		.accessory_limit(acc_lim), .termination_enable(term_en), .charge_disable(chg_dis),
		.high_impedance_select(hiz), .accessory_output_enable(acc_en), .hs_mode(hs_mode));

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// watchdog pulses counted between edges, where the registered output has settled
	always @(negedge clk_sys) begin
		if (kick === 1'b1) kicks <= kicks + 1;
	end
	// run-length guard, a few times the expected length of all tests
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	task automatic chk_val(input string what, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask
	task automatic chk_bit(input string what, input logic e, input logic g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %b seen %b", what, e, g);
		end
	endtask

	// register write of one byte; pointer first, direction bit one means write
	task automatic wr(input logic [7:0] ptr, input logic [7:0] d, output logic dack);
		i_master.start();
		i_master.xfer({`CHGI_SLAVE_ADDR, 1'b1}, 1'b1, x, a);
		chk_bit("write address ack", 1'b0, a);
		i_master.xfer(ptr, 1'b1, x, a);
		i_master.xfer(d, 1'b1, x, dack);
		i_master.stop();
	endtask
	// register read: set pointer, repeated start, one byte, master refuses the next
	task automatic rdr(input logic [7:0] ptr, output logic [7:0] d);
		i_master.start();
		i_master.xfer({`CHGI_SLAVE_ADDR, 1'b1}, 1'b1, x, a);
		i_master.xfer(ptr, 1'b1, x, a);
		i_master.start();
		i_master.xfer({`CHGI_SLAVE_ADDR, 1'b0}, 1'b1, x, a);
		chk_bit("read address ack", 1'b0, a);
		i_master.xfer(8'hFF, 1'b1, d, a);
		i_master.stop();
	endtask
	// control outputs against the model, sampled between edges
	task automatic chk_outs();
		logic [7:0] e;
		// power select needs five clocks through its filter and the limit register
		repeat (8) @(negedge clk_sys);
		e = ctrl_m[7:0];
		if (default_mode) e[7:6] = psel_in ? `CHGI_ILIM_PSEL_HI : `CHGI_ILIM_PSEL_LO;
		chk_val("control outputs", {8'h00, e}, {8'h00, input_limit, acc_lim, term_en, chg_dis,
			hiz, acc_en});
		@(posedge clk_sys);
	endtask
	function automatic logic [15:0] stat_exp();
		return {8'h00, psel_in, en_m[0], charger_status.state, 1'b0, charger_status.fault};
	endfunction

	initial begin
		void'($urandom(29));
		repeat (12) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (12) @(posedge clk_sys);
		// values straight out of reset
		chk_outs();
		chk_bit("hs mode", 1'b0, hs_mode);
		chk_bit("status pin", 1'b1, stat_oe_n);
		rdr(8'h01, rd);
		chk_val("control read", 16'h0030, {8'h00, rd});
		$display("test reset done");
		// all-zero, all-one and random control bytes
		for (int i = 0; i < 6; i++) begin
			ctrl_m = (i == 0) ? 32'h00 : (i == 1) ? 32'hFF : int'($urandom_range(255));
			wr(8'h01, ctrl_m[7:0], ack);
			chk_bit("data ack", 1'b0, ack);
			chk_outs();
			rdr(8'h01, rd);
			chk_val("control read", {8'h00, ctrl_m[7:0]}, {8'h00, rd});
		end
		$display("test control register done");
		// in default mode the limit follows the power select pin
		default_mode <= 1'b1;
		for (int p = 0; p < 2; p++) begin
			psel_in <= p[0];
			@(posedge clk_sys);
			chk_outs();
		end
		default_mode <= 1'b0;
		$display("test default mode done");
		// status byte built from charger state, fault code and power select
		for (int i = 0; i < 4; i++) begin
			charger_status <= 5'($urandom);
			psel_in <= 1'($urandom);
			@(posedge clk_sys);
			rdr(8'h00, rd);
			chk_val("status read", stat_exp(), {8'h00, rd});
		end
		$display("test status register done");
		// kick clears itself and gives one pulse; enable bit is stored
		k0 = kicks;
		wr(8'h00, 8'h80, ack);
		en_m = 0;
		repeat (4) @(posedge clk_sys);
		chk_val("kick pulses", 16'h0001, 16'(kicks - k0));
		rdr(8'h00, rd);
		chk_val("status read", stat_exp(), {8'h00, rd});
		wr(8'h00, 8'h40, ack);
		en_m = 1;
		rdr(8'h00, rd);
		chk_val("status read", stat_exp(), {8'h00, rd});
		chk_val("kick pulses", 16'h0001, 16'(kicks - k0));
		$display("test watchdog done");
		// undefined register and foreign address
		rdr(8'h05, rd);
		chk_val("unmapped read", 16'h00FF, {8'h00, rd});
		i_master.start();
		i_master.xfer({`CHGI_SLAVE_ADDR ^ 7'h01, 1'b1}, 1'b1, x, a);
		chk_bit("foreign address ack", 1'b1, a);
		i_master.stop();
		$display("test addressing done");
		// master code is not acknowledged; stop leaves high-speed settings
		i_master.start();
		i_master.xfer(8'h08 | {5'h00, 3'($urandom)}, 1'b1, x, a);
		chk_bit("master code ack", 1'b1, a);
		chk_bit("hs mode set", 1'b1, hs_mode);
		ctrl_m = 32'h5A;
		wr(8'h01, 8'h5A, ack);
		chk_outs();
		chk_bit("hs mode after stop", 1'b0, hs_mode);
		$display("test high speed done");
		// status pins low while charging, one fixed pulse on a fault
		charger_status <= 5'h08;
		repeat (8) @(negedge clk_sys);
		chk_bit("status pin charging", 1'b0, stat_oe_n);
		chk_bit("int pin charging", 1'b0, int_oe_n);
		@(posedge clk_sys);
		charger_status <= 5'h00;
		repeat (8) @(negedge clk_sys);
		chk_bit("status pin ready", 1'b1, stat_oe_n);
		@(posedge clk_sys);
		charger_status <= 5'h1E;
		n = 0;
		for (int i = 0; i < 20 && int_oe_n !== 1'b0; i++) @(negedge clk_sys);
		while (int_oe_n === 1'b0 && n < 2000) begin
			@(negedge clk_sys);
			n++;
		end
		chk_val("fault pulse cycles", 16'(`CHGI_FAULT_PULSE_CYC), 16'(n));
		$display("test status pins done");
		// stalled drain: eight writes fill the buffer, the ninth byte is refused
		@(posedge clk_sys);
		reg_hold <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			wr(8'h01, 8'h10 + 8'(i), ack);
			chk_bit("buffered write ack", i == 8, ack);
		end
		chk_outs();
		reg_hold <= 1'b0;
		ctrl_m = 32'h17;
		repeat (20) @(posedge clk_sys);
		chk_outs();
		$display("test write buffer done");
		wrap_up();
	end
endmodule
